/* File: rtl/pch_pkg.sv */
package pch_pkg;
   // Configuration dword indexes as seen on the request port
   localparam logic [3:0] IDX_ID = 4'h0;
   localparam logic [3:0] IDX_CMD_STAT = 4'h1;
   localparam logic [3:0] IDX_REV_CLASS = 4'h2;
   localparam logic [3:0] IDX_MISC = 4'h3;
   // Printed byte offsets of the header registers
   localparam logic [7:0] OFS_MAKER_IDENT = 8'h00;
   localparam logic [7:0] OFS_FUNC_IDENT = 8'h02;
   localparam logic [7:0] OFS_HOST_CMD = 8'h04;
   localparam logic [7:0] OFS_HOST_STAT = 8'h06;
   localparam logic [7:0] OFS_STEP_IDENT = 8'h08;
   localparam logic [7:0] OFS_FUNC_CAT = 8'h09;
   localparam logic [7:0] OFS_LINE_SIZE = 8'h0c;
   localparam logic [7:0] OFS_LATENCY = 8'h0d;
   localparam logic [7:0] OFS_LAYOUT = 8'h0e;
   // Command register bit positions
   localparam int CMD_IO_BIT = 0;
   localparam int CMD_MEM_BIT = 1;
   localparam int CMD_BM_BIT = 2;
   localparam int CMD_PER_BIT = 6;
   localparam int CMD_SERR_BIT = 8;
   localparam int CMD_IDIS_BIT = 10;
   // Status register bit positions
   localparam int ST_INT_BIT = 3;
   localparam int ST_CAP_BIT = 4;
   localparam int ST_PAR_BIT = 8;
   localparam int ST_ERR_LSB = 11;
   localparam int ST_ERR_MSB = 15;
   localparam int NUM_ERR = 6;
   // Nonvolatile word addresses and load order
   localparam logic [7:0] NVM_ADR_VENDOR = 8'h0e;
   localparam logic [7:0] NVM_ADR_DEVICE = 8'h0d;
   localparam logic [7:0] NVM_ADR_INIT2 = 8'h19;
   localparam logic [7:0] NVM_ADR_INIT3 = 8'h1a;
   localparam logic [7:0] NVM_ADR_REV = 8'h1e;
   localparam logic [2:0] LD_VENDOR = 3'h0;
   localparam logic [2:0] LD_DEVICE = 3'h1;
   localparam logic [2:0] LD_INIT2 = 3'h2;
   localparam logic [2:0] LD_INIT3 = 3'h3;
   localparam logic [2:0] LD_REV = 3'h4;
   localparam logic [2:0] LD_LAST = 3'h4;
   localparam int NVM_IO_SUP_BIT = 11;
   localparam logic [15:0] NVM_BLANK = 16'hffff;
   // Reset and fixed values
   localparam logic [7:0] LINE_SIZE_RST = 8'h10;
   localparam logic [23:0] CLASS_NET = 24'h020000;
   localparam logic [23:0] CLASS_ALT = 24'h010000;
   localparam logic [7:0] LAYOUT_SINGLE = 8'h00;
   localparam logic [7:0] LATENCY_VAL = 8'h00;
   localparam logic [7:0] SELFTEST_VAL = 8'h00;
   localparam int NVM_WAIT_CYC = 16;

   function automatic logic [7:0] pch_nvm_word(input logic [2:0] idx);
      case (idx)
         LD_VENDOR: pch_nvm_word = NVM_ADR_VENDOR;
         LD_DEVICE: pch_nvm_word = NVM_ADR_DEVICE;
         LD_INIT2: pch_nvm_word = NVM_ADR_INIT2;
         LD_INIT3: pch_nvm_word = NVM_ADR_INIT3;
         default: pch_nvm_word = NVM_ADR_REV;
      endcase
   endfunction : pch_nvm_word
endpackage : pch_pkg

/* File: rtl/pch_nvm_loader.sv */
`timescale 1ns/100ps
`default_nettype none
module pch_nvm_loader
   import pch_pkg::*;
#(
   parameter int WAIT_CYC = NVM_WAIT_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   output logic nvm_req,
   output logic [7:0] nvm_addr,
   input wire logic nvm_ack,
   input wire logic [15:0] nvm_rdata,
   output logic ld_vld,
   output logic ld_ok,
   output logic [2:0] ld_idx,
   output logic [15:0] ld_data,
   output logic ld_done
);
   localparam int CW = $clog2(WAIT_CYC + 1);
   localparam logic [CW-1:0] WAIT_LAST = CW'(WAIT_CYC - 1);

   if (WAIT_CYC < 1) begin : g_chk
      $error("WAIT_CYC must be at least one");
   end

   typedef enum logic [2:0] {
      S_REQ = 3'b001,
      S_WAIT = 3'b010,
      S_DONE = 3'b100
   } pch_ld_state_t;

   typedef struct packed {
      pch_ld_state_t st;
      logic [2:0] idx;
      logic [CW-1:0] cnt;
      logic req;
      logic [7:0] addr;
      logic vld;
      logic ok;
      logic [2:0] vidx;
      logic [15:0] data;
      logic done;
   } pch_ld_t;

   pch_ld_t q, d;

   always_comb begin
      d = q;
      d.vld = 1'b0;
      case (q.st)
         S_REQ: begin
            d.req = 1'b1;
            d.addr = pch_nvm_word(q.idx);
            d.cnt = '0;
            d.st = S_WAIT;
         end
         S_WAIT: begin
            // A silent memory must not stall the header; give up and default
            if (nvm_ack || q.cnt == WAIT_LAST) begin
               d.req = 1'b0;
               d.vld = 1'b1;
               d.ok = nvm_ack;
               d.vidx = q.idx;
               d.data = nvm_rdata;
               if (q.idx == LD_LAST) begin
                  d.st = S_DONE;
               end else begin
                  d.idx = q.idx + 3'h1;
                  d.st = S_REQ;
               end
            end else begin
               d.cnt = q.cnt + CW'(1);
            end
         end
         S_DONE: d.done = 1'b1;
         default: d.st = S_DONE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         q <= '{st: S_REQ, default: '0};
      end else if (ce) begin
         q <= d;
      end
   end

   assign nvm_req = q.req;
   assign nvm_addr = q.addr;
   assign ld_vld = q.vld;
   assign ld_ok = q.ok;
   assign ld_idx = q.vidx;
   assign ld_data = q.data;
   assign ld_done = q.done;
endmodule : pch_nvm_loader
`default_nettype wire

/* File: rtl/pch_config_header.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] Vendor field loads nvm word, defaults otherwise
// [R2] All-ones vendor word falls back to default
// [R3] Device field read-only, loadable from nvm
// [R4] Command enables read-write, reset to zero
// [R5] Unsupported command bits read zero, ignore writes
// [R6] No I/O support forces I/O enable zero
// [R7] Interrupt disable bit blocks legacy interrupt messages
// [R8] Status bit 3 shows pending interrupt
// [R9] Capabilities status bit always reads one
// [R10] Timing and capability status bits hardwired zero
// [R11] Error flags set by hardware, write-one clears
// [R12] Revision is stepping code xor nvm word
// [R13] Class code fixed network controller value
// [R14] Line size read-write, nvm loaded, no effect
// [R15] Latency byte reads zero, writes ignored
// [R16] Layout type reads single-function zero
module pch_config_header
   import pch_pkg::*;
#(
   parameter logic [15:0] VENDOR_DEFAULT = 16'h1a2b, // arbitrary value
   parameter logic [15:0] DEVICE_DEFAULT = 16'h3c4d, // arbitrary value
   parameter logic [7:0] STEP_CODE = 8'h5a, // arbitrary value
   parameter logic [23:0] CLASS_CODE = CLASS_NET,
   parameter int WAIT_CYC = NVM_WAIT_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic cfg_req,
   input wire logic cfg_wr,
   input wire logic [3:0] cfg_idx,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   output logic nvm_req,
   output logic [7:0] nvm_addr,
   input wire logic nvm_ack,
   input wire logic [15:0] nvm_rdata,
   input wire logic [NUM_ERR-1:0] err_event,
   input wire logic intr_pending,
   output logic io_space_en,
   output logic mem_space_en,
   output logic bus_mastering_permit,
   output logic parity_resp_en,
   output logic serr_report_en,
   output logic intr_msg_permit,
   output logic init_done
);
   if (CLASS_CODE != CLASS_NET && CLASS_CODE != CLASS_ALT) begin : g_chk
      $error("CLASS_CODE must be a network controller code");
   end

   typedef struct packed {
      logic [15:0] vend;
      logic [15:0] dev;
      logic io_sup;
      logic [7:0] line;
      logic [7:0] revw;
      logic io;
      logic mem;
      logic bm;
      logic per;
      logic serr;
      logic idis;
      logic [NUM_ERR-1:0] err;
      logic pend;
      logic permit;
      logic done;
      logic ack;
      logic [3:0] ack_idx;
      logic [31:0] rdata;
   } pch_regs_t;

   localparam pch_regs_t RST_VAL = '{
      vend: VENDOR_DEFAULT,
      dev: DEVICE_DEFAULT,
      io_sup: 1'b1,
      line: LINE_SIZE_RST,
      default: '0
   };

   pch_regs_t q, d;
   logic ld_vld;
   logic ld_ok;
   logic [2:0] ld_idx;
   logic [15:0] ld_data;
   logic ld_done;
   logic take;
   logic good;
   logic [15:0] cmd_word;
   logic [15:0] stat_word;
   logic [NUM_ERR-1:0] w1c;

   pch_nvm_loader #(
      .WAIT_CYC(WAIT_CYC)
   ) u_loader (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .ce(ce),
      .nvm_req(nvm_req),
      .nvm_addr(nvm_addr),
      .nvm_ack(nvm_ack),
      .nvm_rdata(nvm_rdata),
      .ld_vld(ld_vld),
      .ld_ok(ld_ok),
      .ld_idx(ld_idx),
      .ld_data(ld_data),
      .ld_done(ld_done)
   );

   // Host is held off until the stored words are in place
   assign take = cfg_req && q.done && !q.ack;
   assign good = ld_ok && ld_data != NVM_BLANK; // see [R2]

   always_comb begin
      cmd_word = '0; // see [R5]
      cmd_word[CMD_IO_BIT] = q.io;
      cmd_word[CMD_MEM_BIT] = q.mem;
      cmd_word[CMD_BM_BIT] = q.bm;
      cmd_word[CMD_PER_BIT] = q.per;
      cmd_word[CMD_SERR_BIT] = q.serr;
      cmd_word[CMD_IDIS_BIT] = q.idis;
      stat_word = '0; // see [R10]
      stat_word[ST_INT_BIT] = q.pend; // see [R8]
      stat_word[ST_CAP_BIT] = 1'b1; // see [R9]
      stat_word[ST_PAR_BIT] = q.err[0];
      stat_word[ST_ERR_MSB:ST_ERR_LSB] = q.err[NUM_ERR-1:1];
   end

   always_comb begin
      w1c = '0;
      if (take && cfg_wr && cfg_idx == IDX_CMD_STAT) begin
         // Status bits 15:8, flag 8 included, all sit in byte 3
         if (cfg_be[3]) begin
            w1c[NUM_ERR-1:1] = cfg_wdata[16+ST_ERR_MSB:16+ST_ERR_LSB];
            w1c[0] = cfg_wdata[16+ST_PAR_BIT];
         end
      end
   end

   always_comb begin
      d = q;
      d.ack = take;
      d.pend = intr_pending;
      d.done = ld_done;
      // Held low while disabled, even if pending stays visible
      d.permit = intr_pending && !q.idis; // see [R7]
      // New events win over a clear in the same cycle
      d.err = (q.err & ~w1c) | err_event; // see [R11]
      if (ld_vld) begin
         case (ld_idx)
            LD_VENDOR: d.vend = good ? ld_data : VENDOR_DEFAULT; // see [R1]
            LD_DEVICE: d.dev = good ? ld_data : DEVICE_DEFAULT; // see [R3]
            LD_INIT2: d.io_sup = good ? ld_data[NVM_IO_SUP_BIT] : 1'b1;
            LD_INIT3: d.line = good ? ld_data[7:0] // see [R14]
                                    : LINE_SIZE_RST;
            LD_REV: d.revw = good ? ld_data[7:0] : 8'h00;
            default: d.revw = q.revw;
         endcase
      end
      if (take) begin
         d.ack_idx = cfg_idx;
         case (cfg_idx)
            IDX_ID: d.rdata = {q.dev, q.vend};
            IDX_CMD_STAT: d.rdata = {stat_word, cmd_word};
            IDX_REV_CLASS: d.rdata = {CLASS_CODE, // see [R13]
                                      STEP_CODE ^ q.revw}; // see [R12]
            IDX_MISC: d.rdata = {SELFTEST_VAL, LAYOUT_SINGLE, LATENCY_VAL,
                                 q.line}; // see [R15] [R16]
            default: d.rdata = '0;
         endcase
         if (cfg_wr && cfg_idx == IDX_CMD_STAT && cfg_be[0]) begin
            d.io = cfg_wdata[CMD_IO_BIT]; // see [R4]
            d.mem = cfg_wdata[CMD_MEM_BIT];
            d.bm = cfg_wdata[CMD_BM_BIT];
            d.per = cfg_wdata[CMD_PER_BIT];
         end
         if (cfg_wr && cfg_idx == IDX_CMD_STAT && cfg_be[1]) begin
            d.serr = cfg_wdata[CMD_SERR_BIT]; // see [R4]
            d.idis = cfg_wdata[CMD_IDIS_BIT]; // see [R7]
         end
         if (cfg_wr && cfg_idx == IDX_MISC && cfg_be[0]) begin
            d.line = cfg_wdata[7:0]; // see [R14]
         end
      end
      if (!d.io_sup) begin
         d.io = 1'b0; // see [R6]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         q <= RST_VAL;
      end else if (ce) begin
         q <= d;
      end
   end

   assign cfg_ack = q.ack;
   assign cfg_rdata = q.rdata;
   assign io_space_en = q.io;
   assign mem_space_en = q.mem;
   assign bus_mastering_permit = q.bm;
   assign parity_resp_en = q.per;
   assign serr_report_en = q.serr;
   assign intr_msg_permit = q.permit;
   assign init_done = q.done;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   property p_vendor_fallback;
      (ce && ld_vld && ld_idx == LD_VENDOR && !good) |=>
         q.vend == VENDOR_DEFAULT;
   endproperty
   a_vendor_fallback: assert property (p_vendor_fallback) // see [R2]
      else $error("vendor did not fall back to default");

   property p_vendor_load;
      (ce && ld_vld && ld_idx == LD_VENDOR && good) |=>
         q.vend == $past(ld_data);
   endproperty
   a_vendor_load: assert property (p_vendor_load) // see [R1]
      else $error("vendor word not loaded");

   property p_device_ro;
      (ce && q.done) |=> $stable(q.dev);
   endproperty
   a_device_ro: assert property (p_device_ro) // see [R3]
      else $error("device field changed after init");

   property p_cmd_read;
      (cfg_ack && q.ack_idx == IDX_CMD_STAT) |->
         cfg_rdata[15:11] == 5'h00 && cfg_rdata[9] == 1'b0 &&
         cfg_rdata[7] == 1'b0 && cfg_rdata[5:3] == 3'h0;
   endproperty
   a_cmd_read: assert property (p_cmd_read) // see [R5]
      else $error("hardwired command bits not zero");

   property p_stat_read;
      (cfg_ack && q.ack_idx == IDX_CMD_STAT) |->
         cfg_rdata[16+ST_CAP_BIT] && cfg_rdata[26:25] == 2'h0 &&
         cfg_rdata[23] == 1'b0 && cfg_rdata[22:21] == 2'h0 &&
         cfg_rdata[18:16] == 3'h0;
   endproperty
   a_stat_read: assert property (p_stat_read) // see [R9] [R10]
      else $error("status fixed bits wrong");

   property p_io_off;
      !q.io_sup |-> !io_space_en;
   endproperty
   a_io_off: assert property (p_io_off) // see [R6]
      else $error("io enable set without io support");

   property p_permit;
      ce |=> intr_msg_permit == $past(intr_pending && !q.idis);
   endproperty
   a_permit: assert property (p_permit) // see [R7]
      else $error("interrupt permit wrong");

   property p_pend;
      ce |=> q.pend == $past(intr_pending);
   endproperty
   a_pend: assert property (p_pend) // see [R8]
      else $error("pending status lags");

   property p_err_set;
      (ce && |err_event) |=> (q.err & $past(err_event)) == $past(err_event);
   endproperty
   a_err_set: assert property (p_err_set) // see [R11]
      else $error("error event lost");

   property p_err_hold;
      (ce && err_event == '0 && w1c == '0) |=> $stable(q.err);
   endproperty
   a_err_hold: assert property (p_err_hold) // see [R11]
      else $error("error flag changed without cause");

   property p_rev_class;
      (cfg_ack && q.ack_idx == IDX_REV_CLASS) |->
         cfg_rdata == {CLASS_CODE, STEP_CODE ^ q.revw};
   endproperty
   a_rev_class: assert property (p_rev_class) // see [R12] [R13]
      else $error("revision or class wrong");

   property p_misc;
      (cfg_ack && q.ack_idx == IDX_MISC) |->
         cfg_rdata[31:8] == 24'h000000 && cfg_rdata[7:0] == $past(q.line);
   endproperty
   a_misc: assert property (p_misc) // see [R14] [R15] [R16]
      else $error("misc dword wrong");

   property p_dev_load;
      (ce && ld_vld && ld_idx == LD_DEVICE) |=>
         q.dev == ($past(good) ? $past(ld_data) : DEVICE_DEFAULT);
   endproperty
   a_dev_load: assert property (p_dev_load) // see [R3]
      else $error("device field not loaded or defaulted");

   property p_rev_load;
      (ce && ld_vld && ld_idx == LD_REV) |=>
         q.revw == ($past(good) ? $past(ld_data[7:0]) : 8'h00);
   endproperty
   a_rev_load: assert property (p_rev_load) // see [R12]
      else $error("revision word not loaded or cleared");

   property p_cmd_write;
      (ce && take && cfg_wr && cfg_idx == IDX_CMD_STAT && cfg_be[0]) |=>
         mem_space_en == $past(cfg_wdata[CMD_MEM_BIT]) &&
         bus_mastering_permit == $past(cfg_wdata[CMD_BM_BIT]) &&
         parity_resp_en == $past(cfg_wdata[CMD_PER_BIT]);
   endproperty
   a_cmd_write: assert property (p_cmd_write) // see [R4]
      else $error("command enable write lost");

   property p_idis_write;
      (ce && take && cfg_wr && cfg_idx == IDX_CMD_STAT && cfg_be[1]) |=>
         q.idis == $past(cfg_wdata[CMD_IDIS_BIT]) &&
         serr_report_en == $past(cfg_wdata[CMD_SERR_BIT]);
   endproperty
   a_idis_write: assert property (p_idis_write) // see [R7]
      else $error("interrupt disable write lost");

   property p_err_clear;
      (ce && w1c != '0 && err_event == '0) |=> (q.err & $past(w1c)) == '0;
   endproperty
   a_err_clear: assert property (p_err_clear) // see [R11]
      else $error("error flag not cleared by write of one");

   property p_line_write;
      (ce && take && cfg_wr && cfg_idx == IDX_MISC && cfg_be[0]) |=>
         q.line == $past(cfg_wdata[7:0]);
   endproperty
   a_line_write: assert property (p_line_write) // see [R14]
      else $error("line size write lost");

   property p_cmd_reset;
      $rose(rst_b) |-> !io_space_en && !mem_space_en &&
         !bus_mastering_permit && !q.idis;
   endproperty
   a_cmd_reset: assert property (p_cmd_reset) // see [R4]
      else $error("command enables not zero after reset");

   c_fallback: cover property (ce && ld_vld && ld_idx == LD_VENDOR && !good);
   c_clear: cover property (ce && w1c != '0);
   c_no_io: cover property (q.done && !q.io_sup);
   c_blocked: cover property (intr_pending && q.idis ##1 !intr_msg_permit);
endmodule : pch_config_header
`default_nettype wire

/* File: tb/pch_nvm_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pch_nvm_model
   import pch_pkg::*;
#(
   parameter logic [15:0] W_VEN = 16'h0,
   parameter logic [15:0] W_DEV = 16'h0,
   parameter logic [15:0] W_IO = 16'h0,
   parameter logic [15:0] W_LINE = 16'h0,
   parameter logic [15:0] W_REV = 16'h0
) (
   input wire logic clk_sys,
   input wire logic nvm_req,
   input wire logic [7:0] nvm_addr,
   input wire logic [1:0] mode,
   input wire logic [1:0] delay,
   output logic nvm_ack,
   output logic [15:0] nvm_rdata
);
   logic [1:0] wait_q = 2'h0;
   logic [15:0] word;
   initial nvm_ack = 1'b0;
   initial nvm_rdata = 16'h0;
   always_comb begin
      case (nvm_addr)
         NVM_ADR_VENDOR: word = W_VEN;
         NVM_ADR_DEVICE: word = W_DEV;
         NVM_ADR_INIT2: word = W_IO;
         NVM_ADR_INIT3: word = W_LINE;
         default: word = W_REV;
      endcase
   end
   // Mode 1 blank, mode 2 silent; idle data toggles so stale words show
   always @(posedge clk_sys) begin
      nvm_ack <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      if (!nvm_req || nvm_ack) begin
         wait_q <= 2'h0;
      end else if (mode != 2'h2 && wait_q == delay) begin
         nvm_ack <= 1'b1;
         nvm_rdata <= (mode == 2'h1) ? NVM_BLANK : word;
      end else begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule : pch_nvm_model
`default_nettype wire

/* File: tb/pch_config_header_test.sv */
`timescale 1ns/100ps
`default_nettype none
module pch_config_header_test;
   import pch_pkg::*;
   localparam logic [15:0] VDEF = 16'h2468; // arbitrary value
   localparam logic [15:0] DDEF = 16'h1357; // arbitrary value
   localparam logic [7:0] STEP = 8'h3c; // arbitrary value
   localparam logic [15:0] NV_VEN = 16'h7788;
   localparam logic [15:0] NV_DEV = 16'h99aa;
   localparam logic [15:0] NV_IO = 16'h0000;
   localparam logic [15:0] NV_LINE = 16'h0020;
   localparam logic [15:0] NV_REV = 16'h0033;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic cfg_req = 1'b0;
   logic cfg_wr = 1'b0;
   logic [3:0] cfg_idx = 4'h0;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic [5:0] err_event = 6'h0;
   logic intr_pending = 1'b0;
   logic [1:0] nv_mode = 2'h0;
   logic [1:0] nv_delay = 2'h0;
   logic cfg_ack, io_space_en, mem_space_en, bus_mastering_permit;
   logic parity_resp_en, serr_report_en, intr_msg_permit, init_done;
   logic nvm_req, nvm_ack;
   logic [31:0] cfg_rdata;
   logic [7:0] nvm_addr;
   logic [15:0] nvm_rdata;
   integer seed = 32'h188ce3b6;
   int n_fail = 0;
   int comparisons = 0;
   logic [31:0] exp_q[$];
   logic [15:0] e_ven, e_dev, e_cmd;
   logic [5:0] e_flag;
   logic [7:0] e_line, e_rev;
   logic e_io, e_pend;

   always #25 clk_sys = ~clk_sys;

   pch_config_header #(
      .VENDOR_DEFAULT(VDEF),
      .DEVICE_DEFAULT(DDEF),
      .STEP_CODE(STEP),
      .WAIT_CYC(4)
   ) u_dut (
      .clk_sys, .rst_b, .ce, .cfg_req, .cfg_wr, .cfg_idx, .cfg_be,
      .cfg_wdata, .cfg_ack, .cfg_rdata, .nvm_req, .nvm_addr, .nvm_ack,
      .nvm_rdata, .err_event, .intr_pending, .io_space_en, .mem_space_en,
      .bus_mastering_permit, .parity_resp_en, .serr_report_en,
      .intr_msg_permit, .init_done
   );
   pch_nvm_model #(
      .W_VEN(NV_VEN), .W_DEV(NV_DEV), .W_IO(NV_IO), .W_LINE(NV_LINE),
      .W_REV(NV_REV)
   ) u_nvm (
      .clk_sys, .nvm_req, .nvm_addr, .mode(nv_mode), .delay(nv_delay),
      .nvm_ack, .nvm_rdata
   );

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: dword %h, want %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: output %b, want %b", $time, got, exp);
      end
   endtask : chk_bit

   function automatic logic [31:0] cur(input logic [3:0] idx);
      logic [15:0] st;
      st = {e_flag[5:1], 2'h0, e_flag[0], 3'h0, 1'b1, e_pend, 3'h0};
      case (idx)
         IDX_ID: cur = {e_dev, e_ven};
         IDX_CMD_STAT: cur = {st, e_cmd};
         IDX_REV_CLASS: cur = {CLASS_NET, e_rev};
         IDX_MISC: cur = {SELFTEST_VAL, LAYOUT_SINGLE, LATENCY_VAL, e_line};
         default: cur = 32'h0;
      endcase
   endfunction : cur

   // Read data is captured at the take, so a write answers the old value
   task automatic cfg_op(input logic wr, input logic [3:0] idx,
         input logic [3:0] be, input logic [31:0] wd);
      int n;
      exp_q.push_back(cur(idx));
      @(negedge clk_sys);
      cfg_req = 1'b1;
      cfg_wr = wr;
      cfg_idx = idx;
      cfg_be = be;
      cfg_wdata = wd;
      n = 0;
      while (cfg_ack !== 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      cfg_req = 1'b0;
      chk_bit(init_done, 1'b1);
      if (n == 100) begin
         n_fail++;
         $display("wrong value at %0t: no acknowledge", $time);
      end
      if (wr && idx == IDX_CMD_STAT) begin
         if (be[0]) e_cmd[7:0] = wd[7:0];
         if (be[1]) e_cmd[15:8] = wd[15:8];
         e_cmd = e_cmd & (e_io ? 16'h0547 : 16'h0546);
         if (be[3]) e_flag = e_flag & ~{wd[31:27], wd[24]};
      end
      if (wr && idx == IDX_MISC && be[0]) e_line = wd[7:0];
   endtask : cfg_op

   task automatic chk_outs;
      repeat (2) @(negedge clk_sys);
      chk_bit(io_space_en, e_cmd[CMD_IO_BIT]);
      chk_bit(mem_space_en, e_cmd[CMD_MEM_BIT]);
      chk_bit(bus_mastering_permit, e_cmd[CMD_BM_BIT]);
      chk_bit(parity_resp_en, e_cmd[CMD_PER_BIT]);
      chk_bit(serr_report_en, e_cmd[CMD_SERR_BIT]);
      chk_bit(intr_msg_permit, e_pend & ~e_cmd[CMD_IDIS_BIT]);
   endtask : chk_outs

   task automatic pulse(input logic [5:0] ev);
      @(negedge clk_sys);
      err_event = ev;
      @(negedge clk_sys);
      err_event = 6'h0;
      e_flag = e_flag | ev;
   endtask : pulse

   task automatic do_reset(input logic [1:0] m);
      @(negedge clk_sys);
      rst_b = 1'b0;
      intr_pending = 1'b0;
      nv_mode = m;
      nv_delay = 2'({$random(seed)} % 3);
      e_cmd = 16'h0;
      e_flag = 6'h0;
      e_pend = 1'b0;
      e_ven = (m == 2'h0) ? NV_VEN : VDEF;
      e_dev = (m == 2'h0) ? NV_DEV : DDEF;
      e_io = (m == 2'h0) ? NV_IO[NVM_IO_SUP_BIT] : 1'b1;
      e_line = (m == 2'h0) ? NV_LINE[7:0] : LINE_SIZE_RST;
      e_rev = STEP ^ ((m == 2'h0) ? NV_REV[7:0] : 8'h0);
      repeat (12) @(negedge clk_sys);
      rst_b = 1'b1;
      chk_bit(init_done, 1'b0);
      chk_bit(nvm_req, 1'b0);
   endtask : do_reset

   always @(negedge clk_sys) begin
      if (cfg_ack === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("wrong value at %0t: unrequested answer", $time);
         end else begin
            chk_word(cfg_rdata, exp_q.pop_front());
         end
      end
   end

   initial begin
      do_reset(2'h0);
      chk_outs;
      cfg_op(1'b0, IDX_ID, 4'h0, $random(seed));
      cfg_op(1'b0, IDX_REV_CLASS, 4'h0, $random(seed));
      cfg_op(1'b1, IDX_MISC, 4'hf, $random(seed));
      cfg_op(1'b1, IDX_ID, 4'hf, 32'hffffffff);
      cfg_op(1'b0, IDX_MISC, 4'h0, $random(seed));
      cfg_op(1'b0, 4'h9, 4'h0, $random(seed));
      cfg_op(1'b1, IDX_CMD_STAT, 4'h3, 32'hffffffff);
      chk_outs;
      pulse(6'h3f);
      cfg_op(1'b1, IDX_CMD_STAT, 4'h7, 32'hffffffff);
      cfg_op(1'b1, IDX_CMD_STAT, 4'h8, 32'h51000000);
      cfg_op(1'b1, IDX_CMD_STAT, 4'h8, 32'h0);
      intr_pending = 1'b1;
      e_pend = 1'b1;
      chk_outs;
      cfg_op(1'b1, IDX_CMD_STAT, 4'h2, 32'h00000400);
      chk_outs;
      cfg_op(1'b1, IDX_CMD_STAT, 4'h2, 32'h0);
      chk_outs;
      for (int i = 0; i < 8; i++) begin
         pulse(6'($random(seed)));
         cfg_op(1'b1, IDX_CMD_STAT, 4'($random(seed)),
            $random(seed));
         chk_outs;
      end
      // Frozen enable must hold the permit although pending drops
      cfg_op(1'b1, IDX_CMD_STAT, 4'h2, 32'h0);
      @(negedge clk_sys);
      ce = 1'b0;
      intr_pending = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk_bit(intr_msg_permit, e_pend & ~e_cmd[CMD_IDIS_BIT]);
      ce = 1'b1;
      e_pend = 1'b0;
      chk_outs;
      cfg_op(1'b0, IDX_CMD_STAT, 4'h0, $random(seed));
      do_reset(2'h1);
      cfg_op(1'b0, IDX_ID, 4'h0, $random(seed));
      cfg_op(1'b0, IDX_REV_CLASS, 4'h0, $random(seed));
      cfg_op(1'b1, IDX_CMD_STAT, 4'h1, 32'h1);
      chk_outs;
      do_reset(2'h2);
      cfg_op(1'b0, IDX_ID, 4'h0, $random(seed));
      cfg_op(1'b0, IDX_MISC, 4'h0, $random(seed));
      complete_run;
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      $display("wrong value at %0t: run did not finish", $time);
      complete_run;
   end
endmodule : pch_config_header_test
`default_nettype wire
